// *** rtl/usb_ep_cfg.sv ***
/*
 * Endpoint FIFO placement, flush, frame capture and host endpoint timing.
 * Assumes a single AHB-Lite master and a packet engine on mclk_i that reports
 * frames, handshakes and FIFO levels per slot; slot = {endpoint, direction},
 * direction 0 transmits and direction 1 receives.
 */
`timescale 1ns/1ps
module usb_ep_cfg
    import usb_ep_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // AHB-Lite slave.
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Packet engine events.
    input  wire logic        sof_i,
    input  wire logic [10:0] frame_num_i,
    input  wire logic [2:0]  resp_slot_i,
    input  wire logic        nak_i,
    input  wire logic        ack_i,
    input  wire logic        rx_pkt_i,
    input  wire logic        rx_read_i,
    input  wire level_t      level_i [SLOTS],
    input  wire logic [2:0]  lookup_slot_i,
    // Mode outputs.
    output logic             host_role_o,
    output logic             hs_enable_o,
    output logic             ping_en_o,
    // Engine commands.
    output logic             flush_o,
    output logic      [2:0]  flush_slot_o,
    output logic             tog_force_o,
    output logic      [2:0]  tog_slot_o,
    output logic             tog_val_o,
    output logic      [7:0]  tx_start_o,
    output logic      [7:0]  in_req_o,
    output logic      [3:0]  rx_release_o,
    output logic      [7:0]  poll_due_o,
    // Slot configuration lookup, one cycle after lookup_slot_i.
    output logic      [12:0] fifo_start_o,
    output logic      [3:0]  fifo_size_o,
    output logic      [6:0]  tgt_addr_o,
    output logic      [3:0]  tgt_ep_o,
    output logic             speed_low_o,
    output logic      [1:0]  xfer_type_o,
    output logic      [10:0] max_payload_o
);
    // Frames for a 2^(v-1) setting; zero means no limit.
    function automatic logic [15:0] pow_frames(input logic [7:0] v);
        if (v == NAK_DISABLE)
            return 16'h0000;
        else if (v >= NAK_MAX)
            return 16'h8000;
        else
            return 16'h0001 << (v - 8'h01);
    endfunction

    // Bytes held by a FIFO of the given size code.
    function automatic level_t size_bytes(input logic [3:0] code);
        return 13'h0008 << code;
    endfunction

    logic [31:0] rd_reg, rd_next;
    logic        wr_reg, wr_next;
    logic [7:0]  wa_reg, wa_next;
    logic [2:0]  ctrl_reg, ctrl_next;
    logic [10:0] frame_reg, frame_next;
    logic [2:0]  sel_reg, sel_next;
    logic [9:0]  start_reg [SLOTS], start_next [SLOTS];
    logic [3:0]  size_reg [SLOTS], size_next [SLOTS];
    logic [6:0]  addr_reg [SLOTS], addr_next [SLOTS];
    logic [10:0] maxp_reg [SLOTS], maxp_next [SLOTS];
    logic [3:0]  tep_reg [SLOTS], tep_next [SLOTS];
    logic [7:0]  ival_reg [SLOTS], ival_next [SLOTS];
    logic [1:0]  type_reg [SLOTS], type_next [SLOTS];
    logic [2:0]  opt_reg [SLOTS], opt_next [SLOTS];
    logic [15:0] fcnt_reg [SLOTS], fcnt_next [SLOTS];
    logic [7:0]  low_reg, low_next, nakact_reg, nakact_next, nakto_reg, nakto_next;
    logic [7:0]  txp_reg, txp_next, rqp_reg, rqp_next, due_reg, due_next;
    logic [7:0]  txs_reg, txs_next, inr_reg, inr_next;
    logic [3:0]  rxr_reg, rxr_next, rel_reg, rel_next;
    logic        fl_reg, fl_next, tg_reg, tg_next, tv_reg, tv_next;
    logic [2:0]  fs_reg, fs_next, ts_reg, ts_next;
    logic [12:0] lk_start_reg, lk_start_next;
    logic [3:0]  lk_size_reg, lk_size_next, lk_tep_reg, lk_tep_next;
    logic [6:0]  lk_addr_reg, lk_addr_next;
    logic        lk_low_reg, lk_low_next;
    logic [1:0]  lk_type_reg, lk_type_next;
    logic [10:0] lk_maxp_reg, lk_maxp_next;
    logic        pen_reg, pen_next;
    logic        host;
    logic        sel_ep0;
    logic [31:0] wd;

    assign host    = ctrl_reg[CTRL_HOST];
    assign sel_ep0 = (sel_reg[2:1] == 2'h0);
    assign wd      = hwdata_i;

    // Bus address phase: zero wait states, so read data is fetched here.
    always_comb
    begin
        wr_next = hsel_i && hready_i && htrans_i[1] && hwrite_i && (hsize_i == 3'h2);
        wa_next = haddr_i;
        rd_next = 32'h0000_0000;
        if (hsel_i && hready_i && htrans_i[1] && !hwrite_i)
        begin
            unique case (haddr_i)
                OFS_CTRL:   rd_next = {29'h0, ctrl_reg};
                OFS_FRAME:  rd_next = {21'h0, frame_reg};
                OFS_SELECT: rd_next = {29'h0, sel_reg};
                OFS_FIFO:   rd_next = sel_ep0 ? {12'h0, EP0_SIZE, 3'h0, EP0_START, 3'h0}
                    : {12'h0, size_reg[sel_reg], 3'h0, start_reg[sel_reg], 3'h0};
                OFS_ADDR:   rd_next = {25'h0, addr_reg[sel_reg]};
                OFS_EPCFG:  rd_next = {ival_reg[sel_reg], 5'h0, type_reg[sel_reg],
                    low_reg[sel_reg], tep_reg[sel_reg], 1'b0, maxp_reg[sel_reg]};
                OFS_OPT:    rd_next = {29'h0, opt_reg[sel_reg]};
                OFS_STATUS: rd_next = {16'h0, nakto_reg, 4'h0, rxr_reg};
                default:    rd_next = 32'h0000_0000;
            endcase
        end
    end

    // Bus registers; the response is always OKAY with no wait states.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            wr_reg <= 1'b0;
            wa_reg <= 8'h00;
            rd_reg <= 32'h0000_0000;
        end
        else
        begin
            wr_reg <= wr_next;
            wa_reg <= wa_next;
            rd_reg <= rd_next;
        end
    end

    // Configuration writes, event tracking and command pulses.
    always_comb
    begin
        logic [15:0] lim;
        logic [15:0] per;
        logic        match;
        ctrl_next = ctrl_reg;
        sel_next = sel_reg;
        frame_next = sof_i ? frame_num_i : frame_reg;
        start_next = start_reg;
        size_next = size_reg;
        addr_next = addr_reg;
        maxp_next = maxp_reg;
        tep_next = tep_reg;
        ival_next = ival_reg;
        type_next = type_reg;
        opt_next = opt_reg;
        low_next = low_reg;
        fcnt_next = fcnt_reg;
        nakact_next = nakact_reg;
        nakto_next = nakto_reg;
        txp_next = txp_reg;
        rqp_next = rqp_reg;
        rxr_next = rxr_reg;
        due_next = 8'h00;
        txs_next = 8'h00;
        inr_next = 8'h00;
        rel_next = 4'h0;
        fl_next = 1'b0;
        tg_next = 1'b0;
        fs_next = fs_reg;
        ts_next = ts_reg;
        tv_next = tv_reg;
        lim = 16'h0000;
        per = 16'h0000;
        match = 1'b0;
        // Software clears come first so that engine sets below win.
        if (wr_reg)
        begin
            unique case (wa_reg)
                OFS_CTRL:   ctrl_next = wd[2:0];
                OFS_SELECT: sel_next = wd[2:0];
                OFS_FIFO:
                    if (!sel_ep0)
                    begin
                        start_next[sel_reg] = wd[12:FIFO_GRAN];
                        size_next[sel_reg] = wd[SIZE_LSB+:4];
                    end
                OFS_ADDR:   addr_next[sel_reg] = wd[6:0];
                OFS_EPCFG:
                begin
                    maxp_next[sel_reg] = wd[10:0];
                    tep_next[sel_reg] = wd[TEP_LSB+:4];
                    low_next[sel_reg] = wd[LOW_BIT];
                    type_next[sel_reg] = wd[TYPE_LSB+:2];
                    ival_next[sel_reg] = wd[IVAL_LSB+:8];
                end
                OFS_OPT:    opt_next[sel_reg] = wd[2:0];
                OFS_CMD:
                begin
                    fl_next = wd[CMD_FLUSH];
                    fs_next = sel_reg;
                    if (wd[CMD_FLUSH])
                    begin
                        txp_next[sel_reg] = 1'b0;
                        rqp_next[sel_reg] = 1'b0;
                        if (sel_reg[0])
                            rxr_next[sel_reg[2:1]] = 1'b0;
                    end
                    if (wd[CMD_TOGGLE] && host)
                    begin
                        tg_next = 1'b1;
                        ts_next = sel_ep0 ? 3'h0 : sel_reg;
                        tv_next = wd[CMD_TOGVAL];
                    end
                    if (wd[CMD_ACK] && sel_reg[0] && rxr_reg[sel_reg[2:1]])
                    begin
                        rxr_next[sel_reg[2:1]] = 1'b0;
                        rel_next[sel_reg[2:1]] = 1'b1;
                    end
                end
                OFS_STATUS:
                begin
                    nakto_next = nakto_reg & ~wd[NAKTO_LSB+:8];
                    rxr_next = rxr_next & ~wd[3:0];
                end
                default: ;
            endcase
        end
        // Ping follows the control value being written, so the output keeps the same timing.
        pen_next = ctrl_next[CTRL_PING] && ctrl_next[CTRL_HOST];
        for (int i = 0; i < SLOTS; i++)
        begin
            match = (resp_slot_i == i[2:0]);
            lim = pow_frames(ival_reg[i]);
            per = (ival_reg[i] == 8'h00) ? 16'h0001 : {8'h00, ival_reg[i]};
            if (host && i >= 2 && type_reg[i] == TYPE_INTERRUPT)
            begin
                if (sof_i && fcnt_reg[i] + 16'h0001 >= per)
                begin
                    due_next[i] = 1'b1;
                    fcnt_next[i] = 16'h0000;
                end
                else if (sof_i)
                    fcnt_next[i] = fcnt_reg[i] + 16'h0001;
            end
            else if (host && i >= 2 && type_reg[i] == TYPE_ISOCHRONOUS)
            begin
                if (sof_i && fcnt_reg[i] + 16'h0001 >= (lim == 16'h0 ? 16'h1 : lim))
                begin
                    due_next[i] = 1'b1;
                    fcnt_next[i] = 16'h0000;
                end
                else if (sof_i)
                    fcnt_next[i] = fcnt_reg[i] + 16'h0001;
            end
            else if (host)
            begin
                // Control, bulk and endpoint zero: count frames of unbroken NAKs.
                if (match && ack_i)
                begin
                    nakact_next[i] = 1'b0;
                    fcnt_next[i] = 16'h0000;
                end
                else if (match && nak_i)
                    nakact_next[i] = 1'b1;
                if (sof_i && nakact_reg[i] && lim != 16'h0000)
                begin
                    if (fcnt_reg[i] + 16'h0001 >= lim)
                    begin
                        nakto_next[i] = 1'b1;
                        nakact_next[i] = 1'b0;
                        fcnt_next[i] = 16'h0000;
                    end
                    else
                        fcnt_next[i] = fcnt_reg[i] + 16'h0001;
                end
            end
            else
            begin
                fcnt_next[i] = 16'h0000;
                nakact_next[i] = 1'b0;
            end
            // Transmit slots send by themselves once a full packet is loaded.
            if (i % 2 == 0)
            begin
                if (level_i[i] < {2'b00, maxp_reg[i]})
                    txp_next[i] = 1'b0;
                else if (opt_reg[i][OPT_ATX] && !txp_reg[i] && maxp_reg[i] != 11'h0)
                begin
                    txs_next[i] = 1'b1;
                    txp_next[i] = 1'b1;
                end
            end
            else
            begin
                if (rx_pkt_i && match)
                begin
                    rqp_next[i] = 1'b0;
                    rxr_next[i/2] = 1'b1;
                end
                else if (host && opt_reg[i][OPT_AREQ] && !rqp_reg[i] && maxp_reg[i] != 11'h0 &&
                    size_bytes(size_reg[i]) - level_i[i] >= {2'b00, maxp_reg[i]})
                begin
                    inr_next[i] = 1'b1;
                    rqp_next[i] = 1'b1;
                end
                if (rx_read_i && match && opt_reg[i][OPT_ACLR] && rxr_reg[i/2]
                    && !rx_pkt_i)
                begin
                    rxr_next[i/2] = 1'b0;
                    rel_next[i/2] = 1'b1;
                end
            end
        end
    end

    // Configuration and event state.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            ctrl_reg <= CTRL_RST;
            sel_reg <= 3'h0;
            pen_reg <= CTRL_RST[CTRL_PING] && CTRL_RST[CTRL_HOST];
            frame_reg <= 11'h000;
            for (int i = 0; i < SLOTS; i++)
            begin
                start_reg[i] <= 10'h000;
                size_reg[i] <= 4'h0;
                addr_reg[i] <= 7'h00;
                maxp_reg[i] <= 11'h000;
                tep_reg[i] <= 4'h0;
                ival_reg[i] <= 8'h00;
                type_reg[i] <= 2'h0;
                opt_reg[i] <= 3'h0;
                fcnt_reg[i] <= 16'h0000;
            end
            {low_reg, nakact_reg, nakto_reg, txp_reg, rqp_reg} <= 40'h00_0000_0000;
            {due_reg, txs_reg, inr_reg, rxr_reg, rel_reg} <= 32'h0000_0000;
            {fl_reg, tg_reg, tv_reg, fs_reg, ts_reg} <= 9'h000;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            sel_reg <= sel_next;
            pen_reg <= pen_next;
            frame_reg <= frame_next;
            start_reg <= start_next;
            size_reg <= size_next;
            addr_reg <= addr_next;
            maxp_reg <= maxp_next;
            tep_reg <= tep_next;
            ival_reg <= ival_next;
            type_reg <= type_next;
            opt_reg <= opt_next;
            fcnt_reg <= fcnt_next;
            {low_reg, nakact_reg, nakto_reg, txp_reg, rqp_reg} <=
                {low_next, nakact_next, nakto_next, txp_next, rqp_next};
            {due_reg, txs_reg, inr_reg, rxr_reg, rel_reg} <=
                {due_next, txs_next, inr_next, rxr_next, rel_next};
            {fl_reg, tg_reg, tv_reg, fs_reg, ts_reg} <=
                {fl_next, tg_next, tv_next, fs_next, ts_next};
        end
    end

    // Lookup for the engine; host fields read zero in device role.
    always_comb
    begin
        logic ep0;
        ep0 = (lookup_slot_i[2:1] == 2'h0);
        lk_start_next = ep0 ? {EP0_START, 3'h0} : {start_reg[lookup_slot_i], 3'h0};
        lk_size_next = ep0 ? EP0_SIZE : size_reg[lookup_slot_i];
        lk_maxp_next = maxp_reg[lookup_slot_i];
        lk_addr_next = host ? addr_reg[lookup_slot_i] : 7'h00;
        lk_tep_next = host ? tep_reg[lookup_slot_i] : 4'h0;
        lk_low_next = host && low_reg[lookup_slot_i];
        lk_type_next = host ? type_reg[lookup_slot_i] : 2'h0;
    end

    // Lookup registers.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            {lk_start_reg, lk_size_reg, lk_maxp_reg} <= 28'h000_0000;
            {lk_addr_reg, lk_tep_reg, lk_low_reg, lk_type_reg} <= 14'h0000;
        end
        else
        begin
            {lk_start_reg, lk_size_reg, lk_maxp_reg} <=
                {lk_start_next, lk_size_next, lk_maxp_next};
            {lk_addr_reg, lk_tep_reg, lk_low_reg, lk_type_reg} <=
                {lk_addr_next, lk_tep_next, lk_low_next, lk_type_next};
        end
    end

    assign hrdata_o = rd_reg;
    // No wait states and no error responses, so these never move.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign host_role_o = ctrl_reg[CTRL_HOST];
    assign hs_enable_o = ctrl_reg[CTRL_HS];
    assign ping_en_o = pen_reg;
    assign {flush_o, flush_slot_o, tog_force_o, tog_slot_o, tog_val_o} =
        {fl_reg, fs_reg, tg_reg, ts_reg, tv_reg};
    assign {tx_start_o, in_req_o, rx_release_o, poll_due_o} = {txs_reg, inr_reg, rel_reg, due_reg};
    assign {fifo_start_o, fifo_size_o, max_payload_o} = {lk_start_reg, lk_size_reg, lk_maxp_reg};
    assign {tgt_addr_o, tgt_ep_o, speed_low_o, xfer_type_o} =
        {lk_addr_reg, lk_tep_reg, lk_low_reg, lk_type_reg};

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    AST_FIFO_ALIGN: assert property (fifo_start_o[2:0] == 3'h0)
        else $error("fifo start not 8-byte aligned");
    AST_EP0_FIXED: assert property (lookup_slot_i[2:1] == 2'h0 |=>
        fifo_start_o == {EP0_START, 3'h0} && fifo_size_o == EP0_SIZE)
        else $error("endpoint zero fifo not fixed");
    AST_FRAME: assert property (sof_i |=> frame_reg == $past(frame_num_i))
        else $error("frame number not captured");
    // A second flush written back to back may hold the pulse for one more cycle.
    AST_FLUSH: assert property (wr_reg && wa_reg == OFS_CMD && hwdata_i[CMD_FLUSH] |=>
        flush_o && flush_slot_o == $past(sel_reg)
        ##1 (!flush_o || $past(wr_reg && wa_reg == OFS_CMD)))
        else $error("flush pulse wrong");
    // Pulses and lookups lag the role by a cycle, so a role change is allowed to drain.
    AST_DEV_QUIET: assert property (!host_role_o && !$past(host_role_o) |->
        poll_due_o == 8'h00 && in_req_o == 8'h00 && tgt_addr_o == 7'h00 ##1 !tog_force_o)
        else $error("host action in device role");
    AST_AUTO_TX: assert property (tx_start_o[2] |-> $past(opt_reg[2][OPT_ATX])
        && $past(level_i[2]) >= {2'b00, $past(maxp_reg[2])})
        else $error("auto transmit without full packet");
    AST_RX_SET: assert property (rx_pkt_i && resp_slot_i == 3'h3 |=> rxr_reg[1])
        else $error("packet ready lost");
    AST_NAKTO: assert property ($rose(nakto_reg[2]) |-> $past(sof_i) && $past(host_role_o)
        && $past(ival_reg[2]) != NAK_DISABLE)
        else $error("nak timeout without frame");
    AST_TOGGLE_EP0: assert property (tog_force_o && tog_slot_o[2:1] == 2'h0
        |-> tog_slot_o[0] == 1'b0)
        else $error("endpoint zero toggle direction used");
endmodule

// *** common/usb_ep_cfg_pkg.sv ***
/*
 * Constants for the endpoint FIFO and host endpoint configuration block.
 * Assumes a 32-bit AHB-Lite register port and a packet engine on the same clock.
 */
package usb_ep_cfg_pkg;
    localparam int NUM_EP = 4;
    localparam int SLOTS  = 8;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_FRAME  = 8'h04;
    localparam logic [7:0] OFS_SELECT = 8'h08;
    localparam logic [7:0] OFS_FIFO   = 8'h0c;
    localparam logic [7:0] OFS_ADDR   = 8'h10;
    localparam logic [7:0] OFS_EPCFG  = 8'h14;
    localparam logic [7:0] OFS_OPT    = 8'h18;
    localparam logic [7:0] OFS_CMD    = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Control, command and option bit positions.
    localparam int CTRL_HOST  = 0;
    localparam int CTRL_HS    = 1;
    localparam int CTRL_PING  = 2;
    localparam int CMD_FLUSH  = 0;
    localparam int CMD_TOGGLE = 1;
    localparam int CMD_TOGVAL = 2;
    localparam int CMD_ACK    = 3;
    localparam int OPT_ATX    = 0;
    localparam int OPT_AREQ   = 1;
    localparam int OPT_ACLR   = 2;
    // Field positions.
    localparam int FIFO_GRAN  = 3;
    localparam int SIZE_LSB   = 16;
    localparam int TEP_LSB    = 12;
    localparam int LOW_BIT    = 16;
    localparam int TYPE_LSB   = 17;
    localparam int IVAL_LSB   = 24;
    localparam int NAKTO_LSB  = 8;
    // Reset values, fixed endpoint zero FIFO and NAK interval codes.
    localparam logic [2:0]  CTRL_RST     = 3'h4;
    localparam logic [9:0]  EP0_START    = 10'h000;
    localparam logic [3:0]  EP0_SIZE     = 4'h3;
    localparam logic [7:0]  NAK_DISABLE  = 8'h00;
    localparam logic [7:0]  NAK_MAX      = 8'h10;
    typedef enum logic [1:0] {
        TYPE_CONTROL     = 2'h0,
        TYPE_ISOCHRONOUS = 2'h1,
        TYPE_BULK        = 2'h2,
        TYPE_INTERRUPT   = 2'h3
    } xfer_type_e;
    typedef logic [12:0] level_t;
endpackage

// *** testbench/usb_engine_model.sv ***
/*
 * Packet engine stand-in facing the endpoint configuration block.
 * Assumes the bench calls its tasks and that it shares mclk_i with the block.
 */
`timescale 1ns/1ps
module usb_engine_model
    import usb_ep_cfg_pkg::*;
(
    // Clock.
    input  wire logic        mclk_i,
    // Events towards the block.
    output logic             sof_o,
    output logic      [10:0] frame_o,
    output logic      [2:0]  slot_o,
    output logic             nak_o,
    output logic             ack_o,
    output logic             pkt_o,
    output logic             read_o,
    output level_t           level_o [SLOTS],
    output logic      [2:0]  look_o
);
    // Idle at time zero; the frame lines carry junk so a stale number is never read as valid.
    initial
    begin
        {sof_o, nak_o, ack_o, pkt_o, read_o, slot_o, look_o} = '0;
        frame_o = 11'h555;
        foreach (level_o[i]) level_o[i] = '0;
    end

    // One frame start, with an optional NAK on a slot in the same cycle.
    task automatic frame(input logic [10:0] n, input logic nk, input logic [2:0] s);
        @(posedge mclk_i);
        sof_o <= 1'b1;
        frame_o <= n;
        nak_o <= nk;
        slot_o <= s;
        @(posedge mclk_i);
        sof_o <= 1'b0;
        nak_o <= 1'b0;
        frame_o <= ~n;
    endtask

    // Changes the byte count that one slot FIFO reports.
    task automatic fill(input int s, input int v);
        @(posedge mclk_i);
        level_o[s] <= level_t'(v);
    endtask

    // One cycle of packet arrival and/or packet read-out on a slot.
    task automatic pulse(input logic [2:0] s, input logic p, input logic r);
        @(posedge mclk_i);
        slot_o <= s;
        pkt_o <= p;
        read_o <= r;
        @(posedge mclk_i);
        pkt_o <= 1'b0;
        read_o <= 1'b0;
    endtask
endmodule

// *** testbench/tb.sv ***
/*
 * Self-checking bench for usb_ep_cfg: AHB-Lite master tasks, a register mirror and
 * pulse monitors. Assumes the engine model drives every event input of the block.
 */
`timescale 1ns/1ps
module tb
    import usb_ep_cfg_pkg::*;
;
    logic mclk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0, sof_i, nak_i, ack_i, rx_pkt_i;
    logic rx_read_i, hreadyout_o, hresp_o, host_role_o, hs_enable_o, ping_en_o, flush_o;
    logic tog_force_o, tog_val_o, ltv;
    logic [7:0] in_req_o;
    logic [3:0] rx_release_o;
    logic [1:0] htrans_i = 0;
    logic [7:0] haddr_i = 0, tx_start_o, rnd = 8'h58;
    logic [31:0] hwdata_i = 0, hrdata_o, rd, ex, m [9][8];
    logic [10:0] frame_num_i;
    logic [2:0] resp_slot_i, lookup_slot_i, flush_slot_o, tog_slot_o, lfs, lts, cur = 0;
    level_t level_i [SLOTS];
    int err_total = 0, check_count = 0, ntx = 0, nfl = 0, ntg = 0, nrl = 0, nir = 0;

    // 25 MHz clock.
    always #20 mclk_i = ~mclk_i;

    usb_ep_cfg u_dut (.mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .sof_i, .frame_num_i, .resp_slot_i, .nak_i, .ack_i, .rx_pkt_i, .rx_read_i, .level_i,
        .lookup_slot_i, .host_role_o, .hs_enable_o, .ping_en_o, .flush_o, .flush_slot_o,
        .tog_force_o, .tog_slot_o, .tog_val_o, .tx_start_o, .in_req_o, .rx_release_o,
        .poll_due_o(), .fifo_start_o(), .fifo_size_o(), .tgt_addr_o(), .tgt_ep_o(),
        .speed_low_o(), .xfer_type_o(), .max_payload_o());

    usb_engine_model eng (.mclk_i, .sof_o(sof_i), .frame_o(frame_num_i), .slot_o(resp_slot_i),
        .nak_o(nak_i), .ack_o(ack_i), .pkt_o(rx_pkt_i), .read_o(rx_read_i),
        .level_o(level_i), .look_o(lookup_slot_i));

    // Pulse monitors keep counts and the qualifiers of the last command seen.
    always @(posedge mclk_i)
    begin
        ntx <= ntx + int'(tx_start_o[2] === 1'b1);
        nfl <= nfl + int'(flush_o === 1'b1);
        ntg <= ntg + int'(tog_force_o === 1'b1);
        nrl <= nrl + int'(rx_release_o[1] === 1'b1);
        nir <= nir + int'(in_req_o[3] === 1'b1);
        if (flush_o === 1'b1) lfs <= flush_slot_o;
        if (tog_force_o === 1'b1) {lts, ltv} <= {tog_slot_o, tog_val_o};
    end

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // Bounded wait for hready; a slave that never answers ends the run.
    task automatic edge_ready();
        for (int n = 0; n < 16; n++)
        begin
            @(posedge mclk_i);
            if (hreadyout_o === 1'b1) return;
        end
        err_total++;
        conclude();
    endtask

    // One single word transfer; the mirror keeps per-slot registers under the selected slot.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        {hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'b1, 2'h2, a, w};
        edge_ready();
        {hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, d};
        edge_ready();
        rd = hrdata_o;
        if (w && a == OFS_SELECT) cur = d[2:0];
        if (w && a >= OFS_FIFO && a <= OFS_OPT) m[a >> 2][cur] = d;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic pause(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        rchk(OFS_CTRL, {29'h0, CTRL_RST});
        rchk(8'h24, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h3);
        pause(1);
        chk({host_role_o, hs_enable_o, ping_en_o}, 32'h6);
        bus(1'b1, OFS_CTRL, 32'h7);
        pause(1);
        chk({host_role_o, hs_enable_o, ping_en_o}, 32'h7);
        $display("test mode done");
        for (int s = 0; s < 8; s++)
        begin
            rnd = lfsr(rnd);
            bus(1'b1, OFS_SELECT, s);
            bus(1'b1, OFS_FIFO, {12'h0, rnd[3:0], 3'h0, rnd, rnd[4:0]});
            bus(1'b1, OFS_ADDR, {24'h0, rnd});
            bus(1'b1, OFS_EPCFG, {8'h2, 5'h0, s[2:1], s[0], 4'h3, 1'b0, 11'h40});
        end
        for (int s = 0; s < 8; s++)
        begin
            bus(1'b1, OFS_SELECT, s);
            ex = s < 2 ? {12'h0, EP0_SIZE, 3'h0, EP0_START, 3'h0} : m[3][s] & 32'hf1ff8;
            rchk(OFS_FIFO, ex);
            rchk(OFS_ADDR, m[4][s] & 32'h7f);
            rchk(OFS_EPCFG, m[5][s] & 32'hff07f7ff);
        end
        $display("test config done");
        eng.frame({rnd, 3'h5}, 1'b0, 3'h0);
        rchk(OFS_FRAME, {21'h0, rnd, 3'h5});
        bus(1'b1, OFS_SELECT, 32'h3);
        bus(1'b1, OFS_CMD, 32'h1);
        pause(2);
        chk(nfl, 32'h1);
        chk({29'h0, lfs}, 32'h3);
        bus(1'b1, OFS_SELECT, 32'h5);
        bus(1'b1, OFS_CMD, 32'h6);
        pause(2);
        chk({28'h0, lts, ltv}, 32'hb);
        bus(1'b1, OFS_SELECT, 32'h1);
        bus(1'b1, OFS_CMD, 32'h2);
        pause(2);
        chk(ntg, 32'h2);
        chk({28'h0, lts, ltv}, 32'h0);
        $display("test commands done");
        bus(1'b1, OFS_SELECT, 32'h2);
        bus(1'b1, OFS_OPT, 32'h1);
        eng.fill(2, 64);
        pause(4);
        chk(ntx, 32'h1);
        eng.fill(2, 0);
        eng.frame(11'h10, 1'b1, 3'h4);
        rchk(OFS_STATUS, 32'h0);
        eng.frame(11'h11, 1'b1, 3'h4);
        eng.frame(11'h12, 1'b1, 3'h4);
        rchk(OFS_STATUS, 32'h1000);
        bus(1'b1, OFS_STATUS, 32'h1000);
        rchk(OFS_STATUS, 32'h0);
        $display("test timing done");
        bus(1'b1, OFS_SELECT, 32'h3);
        eng.pulse(3'h3, 1'b1, 1'b0);
        rchk(OFS_STATUS, 32'h2);
        bus(1'b1, OFS_CMD, 32'h8);
        rchk(OFS_STATUS, 32'h0);
        bus(1'b1, OFS_OPT, 32'h4);
        eng.pulse(3'h3, 1'b1, 1'b0);
        eng.pulse(3'h3, 1'b0, 1'b1);
        rchk(OFS_STATUS, 32'h0);
        chk(nrl, 32'h2);
        bus(1'b1, OFS_FIFO, 32'h0003_0040);
        bus(1'b1, OFS_OPT, 32'h2);
        pause(3);
        chk(nir, 32'h1);
        $display("test receive done");
        conclude();
    end
endmodule
